// file: wakeup_and_interrupt_control.sv
// Wakeup, halt gating, oscillator start-up delay and interrupt sequencing
`timescale 1ns/1ps
// Function
// - One edge bit per wakeup pin; set means falling, clear means rising.
// - Selected edge on a wakeup pin sets and latches its pending bit.
// - Halt request is ignored while any wakeup bit is enabled and pending.
// - Wakeup runs only oscillator and prescaler from FF; clocks released at timeout.
// - Instruction-cycle clock is the oscillator clock divided by ten.
// - Sources: external pin edge, timer underflow or capture, software opcode zero.
// - Maskable interrupt needs global enable and the source's own enable.
// - Acknowledging a hardware interrupt clears the global enable.
// - External edge bit: 0 rising, 1 falling; toggle for both edges.
// - Separate external and timer pending flags, cleared only by software.
// - Setting global enable inside a service routine allows nesting.
// - Software interrupt leaves the global enable unchanged.
// - Acknowledge pushes PC, SP minus two, vectors 00FF, seven cycles; hardware ones clear enable.
// - All returns pop PC and add two to SP; interrupt return sets enable.
// - Single-cycle enable clears may race an interrupt; use multi-cycle clears.
// - Undefined program memory reads 00, the software interrupt opcode.
// - Undefined data memory reads FF.
// - Unbalanced return pops FF bytes, fetches FFFF, and traps.
// - Wakeup registers read/write; enable and edge reset cleared, pending undefined; the code also resets pending to 00.
module wakeup_and_interrupt_control
   import wakeup_pkg::*;
#(
   parameter int PINS = 8
) (
   input wire logic ref_clk, // Oscillator clock, 20 MHz
   input wire logic reset, // Synchronous, active high
   input wire apb_req_t apb_req, // APB request
   output apb_rsp_t apb_rsp, // APB answer
   input wire logic [PINS-1:0] wake_pins, // Wakeup port pins, asynchronous
   input wire logic external_interrupt_pin, // External interrupt pin, asynchronous
   input wire logic timer_event, // Timer underflow or capture pulse
   input wire logic fetch_valid, // Core opcode fetch strobe
   input wire logic [7:0] fetch_opcode, // Fetched opcode
   input wire logic fetch_defined, // Fetch address lies in defined memory
   input wire logic data_read_defined, // Data address lies in defined memory
   input wire logic [7:0] data_read_raw, // Raw data memory read
   input wire logic ret_valid, // Core executes a return
   input wire ret_kind_t ret_kind, // Which return variant
   input wire logic [15:0] pc_in, // Program counter to push
   input wire logic [15:0] pop_addr, // Address popped from the stack
   output logic [7:0] fetch_opcode_out, // Opcode after undefined-memory fill
   output logic [7:0] data_read_out, // Data read after undefined-memory fill
   output logic halted, // Core is halted
   output logic clocks_enabled, // Clocks routed to rest of chip
   output logic cycle_tick, // Instruction-cycle clock pulse
   output logic ack_busy, // Acknowledge sequence running
   output logic [7:0] sp_out, // Stack pointer
   output logic [15:0] pc_out, // Program counter after vector or return
   output logic push_strobe, // Push PC onto stack
   output logic [15:0] push_data // Value pushed
);
   typedef enum {RUN, HALT, STARTUP} power_t;

   power_t power_reg;
   logic [PINS-1:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
   logic [PINS-1:0] wake_edge_reg, wake_enable_reg, wake_pending_reg;
   logic [PINS-1:0] wake_hit;
   logic [2:0] ext_sync_reg;
   logic [5:0] int_ctrl_reg;
   logic [3:0] div_reg;
   logic [7:0] prescale_reg;
   logic [2:0] ack_count_reg;
   logic ack_soft_reg;
   logic wake_request;
   logic ext_edge, take_hw, take_soft, take_any, access, wr_any;
   logic wr_edge, wr_enable, wr_int, wr_pend, wr_halt;
   logic hit_edge, hit_enable, hit_pending, hit_int, hit_halt, hit_status;
   logic [PINS-1:0] wake_pending_next;

   // Address decode shared by the write strobes and the read mux
   always_comb begin
      hit_edge = 1'b0;
      hit_enable = 1'b0;
      hit_pending = 1'b0;
      hit_int = 1'b0;
      hit_halt = 1'b0;
      hit_status = 1'b0;
      if (apb_req.paddr == OFF_WAKE_EDGE) begin
         hit_edge = 1'b1;
      end else if (apb_req.paddr == OFF_WAKE_ENABLE) begin
         hit_enable = 1'b1;
      end else if (apb_req.paddr == OFF_WAKE_PENDING) begin
         hit_pending = 1'b1;
      end else if (apb_req.paddr == OFF_INT_CTRL) begin
         hit_int = 1'b1;
      end else if (apb_req.paddr == OFF_HALT_CTRL) begin
         hit_halt = 1'b1;
      end else if (apb_req.paddr == OFF_CORE_STATUS) begin
         hit_status = 1'b1;
      end
   end

   // Writes land only in the access phase, where pready is high
   assign access = apb_req.psel && apb_req.penable;
   assign wr_any = access && apb_req.pwrite;
   assign wr_edge = wr_any && hit_edge;
   assign wr_enable = wr_any && hit_enable;
   assign wr_int = wr_any && hit_int;
   assign wr_pend = wr_any && hit_pending;
   assign wr_halt = wr_any && hit_halt;
   assign take_any = take_hw || take_soft;

   // Pin synchronisers: the second and third stages feed edge detection
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         pin_prev_reg <= '0;
      end else begin
         pin_meta_reg <= wake_pins;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // External pin: stage 2 synchronises, stage 3 remembers the last level
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ext_sync_reg <= 3'h0;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], external_interrupt_pin};
      end
   end

   genvar i;
   generate
      for (i = 0; i < PINS; i++) begin : g_edge
         // Edge bit set selects falling
         assign wake_hit[i] = wake_edge_reg[i] ? (pin_prev_reg[i] && !pin_sync_reg[i])
                                               : (!pin_prev_reg[i] && pin_sync_reg[i]);
      end
   endgenerate

   assign wake_request = |(wake_enable_reg & wake_pending_reg);

   // Wakeup edge select register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wake_edge_reg <= WAKE_EDGE_RESET[PINS-1:0];
      end else if (wr_edge) begin
         wake_edge_reg <= apb_req.pwdata[PINS-1:0];
      end
   end

   // Wakeup enable register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wake_enable_reg <= WAKE_ENABLE_RESET[PINS-1:0];
      end else if (wr_enable) begin
         wake_enable_reg <= apb_req.pwdata[PINS-1:0];
      end
   end

   // Edge wins over a same-cycle software clear, so no trigger is lost
   always_comb begin
      wake_pending_next = wake_pending_reg | wake_hit;
      if (wr_pend) begin
         wake_pending_next = apb_req.pwdata[PINS-1:0] | wake_hit;
      end
   end

   // Pending: hardware never clears
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wake_pending_reg <= WAKE_PENDING_RESET[PINS-1:0];
      end else begin
         wake_pending_reg <= wake_pending_next;
      end
   end

   // Divide by ten for the instruction-cycle clock
   always_ff @(posedge ref_clk) begin
      if (reset || div_reg == 4'(CYCLE_DIVIDE - 1)) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end
   assign cycle_tick = div_reg == 4'(CYCLE_DIVIDE - 1);

   // Power state: halt, oscillator start-up, run
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         power_reg <= RUN;
         prescale_reg <= STARTUP_PRESCALE_LOAD;
      end else begin
         case (power_reg)
            RUN: begin
               if (wr_halt && apb_req.pwdata[0] && !wake_request) begin
                  power_reg <= HALT;
               end
            end
            HALT: begin
               if (wake_request) begin
                  power_reg <= STARTUP;
                  prescale_reg <= STARTUP_PRESCALE_LOAD;
               end
            end
            STARTUP: begin
               if (cycle_tick) begin
                  if (prescale_reg == 8'h00) begin
                     power_reg <= RUN;
                  end else begin
                     prescale_reg <= prescale_reg - 8'h01;
                  end
               end
            end
            default: power_reg <= RUN;
         endcase
      end
   end
   assign halted = power_reg != RUN;
   assign clocks_enabled = power_reg == RUN;

   assign ext_edge = int_ctrl_reg[BIT_EXTERNAL_EDGE_SELECT] ? (ext_sync_reg[2] && !ext_sync_reg[1])
                                            : (!ext_sync_reg[2] && ext_sync_reg[1]);

   // Maskable take needs global and source enable; same-cycle clear can race
   assign take_hw = clocks_enabled && ack_count_reg == 3'h0 && int_ctrl_reg[BIT_GIE] &&
                    ((int_ctrl_reg[BIT_ENI] && int_ctrl_reg[BIT_EXTERNAL_INTERRUPT_PENDING]) ||
                     (int_ctrl_reg[BIT_TIMER_INTERRUPT_ENABLE] && int_ctrl_reg[BIT_TIMER_INTERRUPT_PENDING]));
   assign fetch_opcode_out = fetch_defined ? fetch_opcode : UNDEF_ROM_DATA;
   assign data_read_out = data_read_defined ? data_read_raw : UNDEF_RAM_DATA;
   assign take_soft = clocks_enabled && ack_count_reg == 3'h0 && !take_hw && fetch_valid &&
                      fetch_opcode_out == SOFT_INT_OPCODE;

   // Interrupt control: pending set wins over software clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         int_ctrl_reg <= INT_CTRL_RESET;
      end else begin
         if (wr_int) begin
            int_ctrl_reg <= apb_req.pwdata[5:0];
         end
         if (ext_edge) begin
            int_ctrl_reg[BIT_EXTERNAL_INTERRUPT_PENDING] <= 1'b1;
         end
         if (timer_event) begin
            int_ctrl_reg[BIT_TIMER_INTERRUPT_PENDING] <= 1'b1;
         end
         if (take_hw) begin
            int_ctrl_reg[BIT_GIE] <= 1'b0;
         end else if (ret_valid && ret_kind == RET_INT) begin
            int_ctrl_reg[BIT_GIE] <= 1'b1;
         end
      end
   end

   // Acknowledge sequence: seven cycles from take to vector
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ack_count_reg <= 3'h0;
      end else if (take_any) begin
         ack_count_reg <= 3'(ACK_CYCLES - 1);
      end else if (ack_count_reg != 3'h0) begin
         ack_count_reg <= ack_count_reg - 3'h1;
      end
   end
   assign ack_busy = ack_count_reg != 3'h0;

   // Kind of the last take, for software to tell traps from hardware sources
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ack_soft_reg <= 1'b0;
      end else if (take_any) begin
         ack_soft_reg <= take_soft;
      end
   end

   // Push strobe lasts one cycle after each take
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         push_strobe <= 1'b0;
      end else begin
         push_strobe <= take_any;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         push_data <= 16'h0000;
      end else if (take_any) begin
         push_data <= pc_in;
      end
   end

   // Stack grows down on take and back up on any return
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sp_out <= 8'h00;
      end else if (take_any) begin
         sp_out <= sp_out - 8'h02;
      end else if (ret_valid) begin
         sp_out <= sp_out + 8'h02;
      end
   end

   // A take outranks a return in the same cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pc_out <= 16'h0000;
      end else if (take_any) begin
         pc_out <= pc_out;
      end else if (ret_valid) begin
         pc_out <= pop_addr;
      end else if (ack_count_reg == 3'h1) begin
         pc_out <= INT_VECTOR;
      end
   end

   // APB read: zero-wait slave, unmapped reads zero with error
   always_comb begin
      apb_rsp.pready = 1'b1;
      apb_rsp.pslverr = 1'b0;
      apb_rsp.prdata = UNMAPPED_READ;
      if (hit_edge) begin
         apb_rsp.prdata[PINS-1:0] = wake_edge_reg;
      end else if (hit_enable) begin
         apb_rsp.prdata[PINS-1:0] = wake_enable_reg;
      end else if (hit_pending) begin
         apb_rsp.prdata[PINS-1:0] = wake_pending_reg;
      end else if (hit_int) begin
         apb_rsp.prdata[5:0] = int_ctrl_reg;
      end else if (hit_halt) begin
         apb_rsp.prdata[0] = halted;
      end else if (hit_status) begin
         apb_rsp.prdata = {7'h00, ack_soft_reg, sp_out, pc_out};
      end else begin
         apb_rsp.pslverr = access;
      end
   end
endmodule : wakeup_and_interrupt_control

// file: wakeup_pkg.sv
// Package: register map, field layout and timing for wakeup and interrupt control
package wakeup_pkg;
   localparam logic [11:0] OFF_WAKE_EDGE = 12'h000;
   localparam logic [11:0] OFF_WAKE_ENABLE = 12'h004;
   localparam logic [11:0] OFF_WAKE_PENDING = 12'h008;
   localparam logic [11:0] OFF_INT_CTRL = 12'h00C;
   localparam logic [11:0] OFF_HALT_CTRL = 12'h010;
   localparam logic [11:0] OFF_CORE_STATUS = 12'h014;
   // Interrupt control bits
   localparam int BIT_GIE = 0;
   localparam int BIT_ENI = 1;
   localparam int BIT_TIMER_INTERRUPT_ENABLE = 2;
   localparam int BIT_EXTERNAL_EDGE_SELECT = 3;
   localparam int BIT_EXTERNAL_INTERRUPT_PENDING = 4;
   localparam int BIT_TIMER_INTERRUPT_PENDING = 5;
   localparam logic [7:0] WAKE_EDGE_RESET = 8'h00;
   localparam logic [7:0] WAKE_ENABLE_RESET = 8'h00;
   localparam logic [7:0] WAKE_PENDING_RESET = 8'h00;
   localparam logic [5:0] INT_CTRL_RESET = 6'h00;
   localparam logic [7:0] STARTUP_PRESCALE_LOAD = 8'hFF;
   localparam int CYCLE_DIVIDE = 10;
   localparam int ACK_CYCLES = 7;
   localparam logic [15:0] INT_VECTOR = 16'h00FF;
   localparam logic [15:0] UNDEF_FETCH_ADDR = 16'hFFFF;
   localparam logic [7:0] UNDEF_ROM_DATA = 8'h00;
   localparam logic [7:0] UNDEF_RAM_DATA = 8'hFF;
   localparam logic [7:0] SOFT_INT_OPCODE = 8'h00;
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   typedef enum logic [1:0] {RET_PLAIN, RET_SKIP, RET_INT} ret_kind_t;
endpackage : wakeup_pkg

// file: wakeup_props.sv
// Checker: port-level properties of wakeup and interrupt control
`timescale 1ns/1ps
module wakeup_props
   import wakeup_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic reset, // Reset
   input wire apb_req_t apb_req, // APB request
   input wire apb_rsp_t apb_rsp, // APB answer
   input wire logic fetch_defined, // Fetch defined
   input wire logic data_read_defined, // Data defined
   input wire logic ret_valid, // Return
   input wire logic [15:0] pc_in, // PC to push
   input wire logic [7:0] fetch_opcode_out, // Filled opcode
   input wire logic [7:0] data_read_out, // Filled data
   input wire logic halted, // Halted
   input wire logic clocks_enabled, // Clocks routed
   input wire logic cycle_tick, // Cycle pulse
   input wire logic ack_busy, // Acknowledge busy
   input wire logic [7:0] sp_out, // Stack pointer
   input wire logic [15:0] pc_out, // PC
   input wire logic push_strobe, // Push
   input wire logic [15:0] push_data // Pushed value
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   wire logic acc = apb_req.psel && apb_req.penable;
   chk_zero_wait: assert property (acc |-> apb_rsp.pready)
      else $error("pready low in access");
   chk_unmapped_err: assert property (acc && apb_req.paddr > OFF_CORE_STATUS |-> apb_rsp.pslverr)
      else $error("no error on unmapped access");
   chk_rom_fill: assert property (!fetch_defined |-> fetch_opcode_out == 8'h00)
      else $error("undefined fetch not zero");
   chk_ram_fill: assert property (!data_read_defined |-> data_read_out == 8'hFF)
      else $error("undefined data not all ones");
   chk_push_frame: assert property ($rose(push_strobe) |->
      push_data == $past(pc_in) && sp_out == $past(sp_out) - 8'h02)
      else $error("bad push frame");
   chk_vector_time: assert property ($rose(push_strobe) |->
      ack_busy [*6] ##1 (!ack_busy && pc_out == INT_VECTOR))
      else $error("vector timing wrong");
   chk_ret_sp: assert property (ret_valid && !ack_busy |=> sp_out == $past(sp_out) + 8'h02)
      else $error("return did not add two");
   chk_tick_gap: assert property (cycle_tick |=> !cycle_tick [*8] ##2 cycle_tick)
      else $error("cycle tick period wrong");
   chk_halt_gate: assert property (halted |-> !clocks_enabled)
      else $error("clocks routed while halted");
   chk_halt_cause: assert property ($rose(halted) |->
      $past(acc && apb_req.pwrite && apb_req.paddr == OFF_HALT_CTRL))
      else $error("halt without request");
   cover property ($rose(push_strobe));
   cover property ($rose(halted));
   cover property (ret_valid);
endmodule : wakeup_props
bind wakeup_and_interrupt_control wakeup_props u_props (.ref_clk(ref_clk), .reset(reset),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .fetch_defined(fetch_defined),
   .data_read_defined(data_read_defined), .ret_valid(ret_valid), .pc_in(pc_in),
   .fetch_opcode_out(fetch_opcode_out), .data_read_out(data_read_out), .halted(halted),
   .clocks_enabled(clocks_enabled), .cycle_tick(cycle_tick), .ack_busy(ack_busy),
   .sp_out(sp_out), .pc_out(pc_out), .push_strobe(push_strobe), .push_data(push_data));

// file: pin_model.sv
// Partner: port pins driven from outside, prompt or slow
`timescale 1ns/1ps
module pin_model (
   input wire logic ref_clk, // Clock
   input wire logic [7:0] want_pins, // Requested pin levels
   input wire logic want_ext, // Requested external level
   input wire logic slow, // Lag one cycle
   output logic [7:0] wake_pins, // Wakeup pins
   output logic external_interrupt_pin // External pin
);
   logic [7:0] dly_pins;
   logic dly_ext;
   // A sluggish driver moves a cycle late
   always_ff @(posedge ref_clk) begin
      dly_pins <= want_pins;
      dly_ext <= want_ext;
   end
   assign wake_pins = slow ? dly_pins : want_pins;
   assign external_interrupt_pin = slow ? dly_ext : want_ext;
endmodule : pin_model

// file: tb.sv
// Testbench: wakeup, halt and interrupt sequencing
`timescale 1ns/1ps
module tb;
   import wakeup_pkg::*;
   logic ref_clk, reset, slow, want_ext, ext_pin, timer_event, fetch_valid, fetch_defined;
   logic data_read_defined, ret_valid, halted, clocks_enabled, cycle_tick, ack_busy;
   logic push_strobe;
   logic [7:0] want_pins, wake_pins, fetch_opcode, data_read_raw, fetch_opcode_out;
   logic [7:0] data_read_out, sp_out, exp_sp, e;
   logic [15:0] pc_in, pop_addr, pc_out, push_data;
   logic [31:0] seed, q;
   apb_req_t req;
   apb_rsp_t rsp;
   ret_kind_t ret_kind;
   int bad_count, checks_done;
   wakeup_and_interrupt_control dut (.ref_clk(ref_clk), .reset(reset), .apb_req(req),
      .apb_rsp(rsp), .wake_pins(wake_pins), .external_interrupt_pin(ext_pin),
      .timer_event(timer_event), .fetch_valid(fetch_valid), .fetch_opcode(fetch_opcode),
      .fetch_defined(fetch_defined), .data_read_defined(data_read_defined),
      .data_read_raw(data_read_raw), .ret_valid(ret_valid), .ret_kind(ret_kind),
      .pc_in(pc_in), .pop_addr(pop_addr), .fetch_opcode_out(fetch_opcode_out),
      .data_read_out(data_read_out), .halted(halted), .clocks_enabled(clocks_enabled),
      .cycle_tick(cycle_tick), .ack_busy(ack_busy), .sp_out(sp_out), .pc_out(pc_out),
      .push_strobe(push_strobe), .push_data(push_data));
   pin_model u_pins (.ref_clk(ref_clk), .want_pins(want_pins), .want_ext(want_ext),
      .slow(slow), .wake_pins(wake_pins), .external_interrupt_pin(ext_pin));
   always #25 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic results();
      if (bad_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (rsp.pready !== 1'b1 && n < 20);
      if (rsp.pready !== 1'b1) begin
         cmp(0, 1);
         results();
      end
      q = rsp.prdata;
      req <= '0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 0);
      cmp(q, exp);
   endtask : rd
   // Records any push in the window, not only the last cycle
   task automatic wait_push(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (12) begin
         @(posedge ref_clk);
         seen |= (push_strobe === 1'b1);
      end
      cmp(seen, exp);
      if (seen) begin
         exp_sp = exp_sp - 8'h02;
         cmp(sp_out, exp_sp);
         cmp(push_data, pc_in);
         cmp(pc_out, INT_VECTOR);
      end
   endtask : wait_push
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      results();
   end
   initial begin
      {ref_clk, slow, want_ext, timer_event, fetch_valid, ret_valid, want_pins} = '0;
      {fetch_opcode, data_read_raw, pc_in, pop_addr, exp_sp, q} = '0;
      {fetch_defined, data_read_defined, reset} = 3'h7;
      req = '0;
      ret_kind = RET_PLAIN;
      seed = 32'h636F;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      rd(OFF_WAKE_EDGE, 0);
      rd(OFF_WAKE_ENABLE, 0);
      rd(12'h020, UNMAPPED_READ);
      seed = xs(seed);
      e = seed[7:0];
      want_pins <= e;
      apb(1'b1, OFF_WAKE_EDGE, e);
      rd(OFF_WAKE_EDGE, e);
      apb(1'b1, OFF_WAKE_PENDING, 0);
      want_pins <= ~e;
      repeat (6) @(posedge ref_clk);
      rd(OFF_WAKE_PENDING, 32'hFF);
      apb(1'b1, OFF_WAKE_PENDING, 0);
      want_pins <= e;
      repeat (6) @(posedge ref_clk);
      rd(OFF_WAKE_PENDING, 0);
      want_pins <= ~e;
      repeat (6) @(posedge ref_clk);
      apb(1'b1, OFF_WAKE_ENABLE, 1);
      apb(1'b1, OFF_HALT_CTRL, 1);
      rd(OFF_HALT_CTRL, 0);
      apb(1'b1, OFF_WAKE_ENABLE, 0);
      apb(1'b1, OFF_WAKE_PENDING, 0);
      apb(1'b1, OFF_WAKE_ENABLE, 1);
      apb(1'b1, OFF_HALT_CTRL, 1);
      @(negedge ref_clk);
      cmp({halted, clocks_enabled}, 2'b10);
      slow <= 1'b1;
      want_pins <= e;
      repeat (6) @(posedge ref_clk);
      want_pins <= ~e;
      // 256 cycle ticks of ten clocks each before clocks return
      repeat (2400) @(posedge ref_clk);
      cmp(clocks_enabled, 0);
      repeat (600) if (clocks_enabled !== 1'b1) @(posedge ref_clk);
      cmp({halted, clocks_enabled}, 2'b01);
      slow <= 1'b0;
      seed = xs(seed);
      pc_in <= seed[15:0];
      apb(1'b1, OFF_INT_CTRL, 32'h02);
      want_ext <= 1'b1;
      wait_push(1'b0);
      rd(OFF_INT_CTRL, 32'h12);
      apb(1'b1, OFF_INT_CTRL, 32'h13);
      wait_push(1'b1);
      rd(OFF_INT_CTRL, 32'h12);
      apb(1'b1, OFF_INT_CTRL, 32'h13);
      wait_push(1'b1);
      apb(1'b1, OFF_INT_CTRL, 32'h13);
      apb(1'b1, OFF_INT_CTRL, 32'h10);
      repeat (8) @(posedge ref_clk);
      exp_sp = exp_sp - 8'h02;
      cmp(sp_out, exp_sp);
      cmp(pc_out, INT_VECTOR);
      apb(1'b1, OFF_INT_CTRL, 32'h0A);
      want_ext <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd(OFF_INT_CTRL, 32'h1A);
      apb(1'b1, OFF_INT_CTRL, 32'h05);
      timer_event <= 1'b1;
      @(posedge ref_clk);
      timer_event <= 1'b0;
      wait_push(1'b1);
      rd(OFF_INT_CTRL, 32'h24);
      apb(1'b1, OFF_INT_CTRL, 32'h04);
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         pop_addr <= seed[15:0];
         ret_kind <= ret_kind_t'(k);
         ret_valid <= 1'b1;
         @(posedge ref_clk);
         ret_valid <= 1'b0;
         @(negedge ref_clk);
         exp_sp = exp_sp + 8'h02;
         cmp(sp_out, exp_sp);
         cmp(pc_out, pop_addr);
         @(posedge ref_clk);
      end
      rd(OFF_INT_CTRL, 32'h05);
      fetch_defined <= 1'b0;
      fetch_opcode <= seed[23:16] | 8'h01;
      data_read_defined <= 1'b0;
      fetch_valid <= 1'b1;
      @(negedge ref_clk);
      cmp(fetch_opcode_out, UNDEF_ROM_DATA);
      cmp(data_read_out, UNDEF_RAM_DATA);
      @(posedge ref_clk);
      fetch_valid <= 1'b0;
      wait_push(1'b1);
      rd(OFF_INT_CTRL, 32'h05);
      ret_kind <= RET_SKIP;
      ret_valid <= 1'b1;
      @(posedge ref_clk);
      ret_valid <= 1'b0;
      @(negedge ref_clk);
      exp_sp = exp_sp + 8'h02;
      cmp(sp_out, exp_sp);
      cmp(pc_out, pop_addr);
      results();
   end
endmodule : tb
